// [flash_write_control_regs.vh]
// register offsets, bit positions, reset values and constants of the flash write control block
`ifndef FLASH_WRITE_CONTROL_REGS_VH
`define FLASH_WRITE_CONTROL_REGS_VH

`define CTRL_LOW_ADDR 24'h080000
`define CTRL_HIGH_ADDR 24'h080002
`define PERIPH_LO_ADDR 24'h080004
`define PERIPH_HI_ADDR 24'h080015
`define BANK_HI_ADDR 24'h04ffff
`define PROT_LO_ADDR 24'h08dfb0
`define PROT_HI_ADDR 24'h08dfbf
`define TEST_HI_ADDR 24'h001fff

`define TRAP_VALUE 16'h009b
`define CTRL_LOW_RESET 16'h0000
`define CTRL_HIGH_RESET 16'h0000

`define LOCK_BIT 4
`define BUSY_BIT 1
`define WMS_BIT 15
`define SUSPEND_BIT_BIT 14
`define WPG_BIT 13
`define DOUBLE_WORD_PROGRAM_SELECT_BIT 12
`define SER_BIT 11
`define SPR_BIT 8

`define KIND_WORD 2'h0
`define KIND_DWORD 2'h1
`define KIND_ERASE 2'h2
`define KIND_PROT 2'h3

`endif

// [flash_region_decode.v]
// address decode of the flash bank, the control registers and the other flash registers
`default_nettype none
`include "flash_write_control_regs.vh"

module flash_region_decode (
   input wire [23:0] addr_i,
   output wire ctrl_low_o,
   output wire ctrl_high_o,
   output wire periph_o,
   output wire bank_o,
   output wire test_zone_o
);

   wire [23:0] word_addr;

   // 8-bit accesses hit the same 16-bit register as the even byte
   assign word_addr = {addr_i[23:1], 1'b0};
   assign ctrl_low_o = (word_addr == `CTRL_LOW_ADDR);
   assign ctrl_high_o = (word_addr == `CTRL_HIGH_ADDR);
   assign periph_o = (addr_i >= `PERIPH_LO_ADDR) && (addr_i <= `PERIPH_HI_ADDR);
   // protection registers live inside the bank, so they follow the bank gating
   assign bank_o = (addr_i <= `BANK_HI_ADDR) || ((addr_i >= `PROT_LO_ADDR) && (addr_i <= `PROT_HI_ADDR));
   assign test_zone_o = (addr_i <= `TEST_HI_ADDR);

endmodule
`default_nettype wire

// [op_request_check.v]
// checks a start request for a legal operation and merges program data into a cell
`default_nettype none
`include "flash_write_control_regs.vh"

module op_request_check (
   input wire [3:0] sel_i,
   input wire [23:0] target_addr_i,
   input wire [5:0] sector_sel_i,
   input wire [31:0] cell_old_i,
   input wire [31:0] cell_data_i,
   output reg [1:0] kind_o,
   output reg bad_o,
   output wire [31:0] merged_o
);

   // program can only pull ones to zeros
   assign merged_o = cell_old_i & cell_data_i;

   always @* begin
      kind_o = `KIND_WORD;
      bad_o = 1'b0;
      case (sel_i)
         4'h1: begin
            kind_o = `KIND_WORD;
            bad_o = (target_addr_i[1:0] != 2'h0);
         end
         4'h2: begin
            kind_o = `KIND_DWORD;
            bad_o = (target_addr_i[2:0] != 3'h0);
         end
         4'h4: begin
            kind_o = `KIND_ERASE;
            bad_o = (sector_sel_i == 6'h00);
         end
         4'h8: begin
            kind_o = `KIND_PROT;
            bad_o = (target_addr_i < `PROT_LO_ADDR) || (target_addr_i > `PROT_HI_ADDR);
         end
         default: begin
            bad_o = 1'b1;
         end
      endcase
   end

endmodule
`default_nettype wire

// [flash_write_control.v]
// control and status of write operations on the program flash bank, with bank and register gating
`default_nettype none
`include "flash_write_control_regs.vh"

// Behaviour
// - busy flag is high while an operation runs; set when write start is set
// - set-protection start also raises the busy flag
// - while busy, bank reads return 009Bh and bank writes are dropped
// - busy clears on completion or suspend; set again on resume
// - while locked, flash register reads return 009Bh, writes do nothing; the suspend bit stays writable while a program or erase runs
// - lock flag sets at the moment write start is set
// - lock flag is always readable; software polls it before other accesses
// - error register updates only after busy has cleared
// - test sector never writable; visible only in bootstrap mode
// - set-protection needs select, address and data loaded before start
// - set-protection outside the protection range flags a sequence error
// - protection select clears when set-protection finishes
// - erase needs erase select and at least one sector, never the test sector
// - erase pre-programs the chosen sectors to 0x00 by itself
// - erase select clears when erase finishes
// - double-word program needs an even-word address and both data words
// - double-word select clears when double-word program finishes
// - word program needs select, address and data loaded before start
// - program only clears ones; word select clears when word program finishes
// - start bit 15, suspend 14, word 13, double word 12, erase 11
// - write start launches or resumes; hardware clears it; software clear ignored
// - suspend halts program or erase; resume needs start plus original select
module flash_write_control (
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire bus_req_i,
   input wire bus_wr_i,
   input wire [23:0] bus_addr_i,
   input wire [1:0] bus_be_i,
   input wire [15:0] bus_wdata_i,
   input wire bootstrap_i,
   input wire [15:0] ext_rdata_i,
   input wire error_flag_i,
   input wire [23:0] target_addr_i,
   input wire [5:0] sector_sel_i,
   input wire op_done_i,
   input wire [31:0] cell_old_i,
   input wire [31:0] cell_data_i,
   output reg bus_ack_o,
   output reg [15:0] bus_rdata_o,
   output reg ext_wr_o,
   output reg [23:0] ext_addr_o,
   output reg [1:0] ext_be_o,
   output reg [15:0] ext_wdata_o,
   output reg test_sel_o,
   output reg op_start_o,
   output reg [1:0] op_kind_o,
   output reg op_phase_o,
   output reg op_suspend_o,
   output reg op_resume_o,
   output reg seq_err_o,
   output reg err_update_o,
   output reg [31:0] cell_wdata_o,
   output reg bank_busy_o,
   output reg reg_lock_o
);

   // finish and unlock are split so the error register moves while the lock still holds software off
   localparam ST_IDLE = 3'd0;
   localparam ST_RUN = 3'd1;
   localparam ST_FINISH = 3'd2;
   localparam ST_UNLOCK = 3'd3;
   localparam ST_SUSPEND_BIT = 3'd4;

   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg busy_ff;
   reg nxt_busy;
   reg lock_ff;
   reg nxt_lock;
   reg wms_ff;
   reg nxt_wms;
   reg suspend_bit_ff;
   reg nxt_suspend_bit;
   // select bits indexed by operation kind: word, double word, erase, protection
   reg [3:0] sel_ff;
   reg [3:0] nxt_sel;
   reg [1:0] kind_ff;
   reg [1:0] nxt_kind;
   reg phase_ff;
   reg nxt_phase;
   reg seq_pend_ff;
   reg nxt_seq_pend;
   reg nxt_start;
   reg nxt_suspend;
   reg nxt_resume;
   reg nxt_seq_err;
   reg nxt_err_update;
   reg [15:0] low_view;
   reg [15:0] high_view;
   reg [15:0] nxt_rdata;

   wire is_ctrl_low;
   wire is_ctrl_high;
   wire is_periph;
   wire is_bank;
   wire is_test_zone;
   wire [1:0] chk_kind;
   wire chk_bad;
   wire [31:0] merged;
   wire wr_high;
   wire start_req;
   wire [3:0] wsel;
   wire bank_wr_ok;
   wire periph_wr_ok;

   flash_region_decode u_decode (
      .addr_i(bus_addr_i),
      .ctrl_low_o(is_ctrl_low),
      .ctrl_high_o(is_ctrl_high),
      .periph_o(is_periph),
      .bank_o(is_bank),
      .test_zone_o(is_test_zone)
   );

   op_request_check u_check (
      .sel_i(wsel),
      .target_addr_i(target_addr_i),
      .sector_sel_i(sector_sel_i),
      .cell_old_i(cell_old_i),
      .cell_data_i(cell_data_i),
      .kind_o(chk_kind),
      .bad_o(chk_bad),
      .merged_o(merged)
   );

   // all control bits sit in the upper byte, so only that lane counts
   assign wr_high = bus_req_i & bus_wr_i & is_ctrl_high & bus_be_i[1];
   assign wsel = {bus_wdata_i[`SPR_BIT], bus_wdata_i[`SER_BIT],
                  bus_wdata_i[`DOUBLE_WORD_PROGRAM_SELECT_BIT], bus_wdata_i[`WPG_BIT]};
   assign start_req = wr_high & bus_wdata_i[`WMS_BIT];

   // test sector refuses every write and is only reachable for reads in bootstrap mode
   assign bank_wr_ok = is_bank & ~busy_ff & ~is_test_zone;
   assign periph_wr_ok = is_periph & ~lock_ff;

   // operation sequencer
   always @* begin
      nxt_state = state_ff;
      nxt_busy = busy_ff;
      nxt_lock = lock_ff;
      nxt_wms = wms_ff;
      nxt_suspend_bit = suspend_bit_ff;
      nxt_sel = sel_ff;
      nxt_kind = kind_ff;
      nxt_phase = phase_ff;
      nxt_seq_pend = seq_pend_ff;
      nxt_start = 1'b0;
      nxt_suspend = 1'b0;
      nxt_resume = 1'b0;
      nxt_seq_err = 1'b0;
      nxt_err_update = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (wr_high) begin
               // software writes to the start bit never store directly
               nxt_sel = wsel;
               nxt_suspend_bit = bus_wdata_i[`SUSPEND_BIT_BIT];
            end
            // a start in the same write as the suspend bit is refused as well
            if (start_req & ~error_flag_i & ~suspend_bit_ff & ~bus_wdata_i[`SUSPEND_BIT_BIT]) begin
               nxt_wms = 1'b1;
               nxt_busy = 1'b1;
               nxt_lock = 1'b1;
               nxt_kind = chk_kind;
               // erase runs a pre-program phase first
               nxt_phase = (chk_kind != `KIND_ERASE);
               // a bad select or target goes straight to finish without starting the array
               if (chk_bad) begin
                  nxt_seq_pend = 1'b1;
                  nxt_state = ST_FINISH;
               end else begin
                  nxt_start = 1'b1;
                  nxt_state = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            if (op_done_i) begin
               if (!phase_ff) begin
                  nxt_phase = 1'b1;
                  nxt_start = 1'b1;
               end else begin
                  // busy falls one edge later, in finish
                  nxt_state = ST_FINISH;
               end
            end else if (wr_high & bus_wdata_i[`SUSPEND_BIT_BIT] & (kind_ff != `KIND_PROT)) begin
               // suspend must stay writable while the lock is up, else it could never act
               nxt_suspend_bit = 1'b1;
               nxt_suspend = 1'b1;
               nxt_busy = 1'b0;
               nxt_wms = 1'b0;
               nxt_lock = 1'b0;
               nxt_state = ST_SUSPEND_BIT;
            end
         end
         ST_FINISH: begin
            nxt_busy = 1'b0;
            nxt_wms = 1'b0;
            nxt_sel[kind_ff] = 1'b0;
            nxt_suspend_bit = 1'b0;
            // error register is told to update only now that busy is low
            nxt_err_update = 1'b1;
            nxt_seq_err = seq_pend_ff;
            nxt_seq_pend = 1'b0;
            nxt_state = ST_UNLOCK;
         end
         ST_UNLOCK: begin
            nxt_lock = 1'b0;
            nxt_state = ST_IDLE;
         end
         ST_SUSPEND_BIT: begin
            if (wr_high) begin
               nxt_sel = wsel;
               nxt_suspend_bit = bus_wdata_i[`SUSPEND_BIT_BIT];
            end
            // only the suspended operation may be resumed; new starts are ignored here
            if (start_req & wsel[kind_ff] & ~error_flag_i) begin
               nxt_suspend_bit = 1'b0;
               nxt_wms = 1'b1;
               nxt_busy = 1'b1;
               nxt_lock = 1'b1;
               nxt_resume = 1'b1;
               nxt_state = ST_RUN;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_ff <= ST_IDLE;
         busy_ff <= 1'b0;
         lock_ff <= 1'b0;
         wms_ff <= 1'b0;
         suspend_bit_ff <= 1'b0;
         sel_ff <= 4'h0;
         kind_ff <= `KIND_WORD;
         phase_ff <= 1'b0;
         seq_pend_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         busy_ff <= nxt_busy;
         lock_ff <= nxt_lock;
         wms_ff <= nxt_wms;
         suspend_bit_ff <= nxt_suspend_bit;
         sel_ff <= nxt_sel;
         kind_ff <= nxt_kind;
         phase_ff <= nxt_phase;
         seq_pend_ff <= nxt_seq_pend;
      end
   end

   // register views
   // reserved bits of both views read as zero
   always @* begin
      low_view = `CTRL_LOW_RESET;
      low_view[`LOCK_BIT] = lock_ff;
      low_view[`BUSY_BIT] = busy_ff;
      high_view = `CTRL_HIGH_RESET;
      high_view[`WMS_BIT] = wms_ff;
      high_view[`SUSPEND_BIT_BIT] = suspend_bit_ff;
      high_view[`WPG_BIT] = sel_ff[0];
      high_view[`DOUBLE_WORD_PROGRAM_SELECT_BIT] = sel_ff[1];
      high_view[`SER_BIT] = sel_ff[2];
      high_view[`SPR_BIT] = sel_ff[3];
   end

   // read answer mux, sampled on the request edge
   // unmapped reads answer zero but are still acknowledged
   always @* begin
      nxt_rdata = 16'h0000;
      if (bus_req_i & ~bus_wr_i) begin
         if (is_ctrl_low) begin
            nxt_rdata = low_view;
         end else if (is_ctrl_high) begin
            nxt_rdata = lock_ff ? `TRAP_VALUE : high_view;
         end else if (is_periph) begin
            nxt_rdata = lock_ff ? `TRAP_VALUE : ext_rdata_i;
         end else if (is_bank) begin
            if (busy_ff) begin
               nxt_rdata = `TRAP_VALUE;
            end else begin
               nxt_rdata = ext_rdata_i;
            end
         end
      end
   end

   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bus_ack_o <= 1'b0;
         bus_rdata_o <= 16'h0000;
         ext_wr_o <= 1'b0;
         ext_addr_o <= 24'h000000;
         ext_be_o <= 2'h0;
         ext_wdata_o <= 16'h0000;
         test_sel_o <= 1'b0;
         op_start_o <= 1'b0;
         op_kind_o <= `KIND_WORD;
         op_phase_o <= 1'b0;
         op_suspend_o <= 1'b0;
         op_resume_o <= 1'b0;
         seq_err_o <= 1'b0;
         err_update_o <= 1'b0;
         cell_wdata_o <= 32'h00000000;
         bank_busy_o <= 1'b0;
         reg_lock_o <= 1'b0;
      end else begin
         bus_ack_o <= bus_req_i;
         bus_rdata_o <= nxt_rdata;
         // forwarded writes are already filtered by busy and lock
         ext_wr_o <= bus_req_i & bus_wr_i & (bank_wr_ok | periph_wr_ok);
         ext_addr_o <= bus_addr_i;
         ext_be_o <= bus_be_i;
         ext_wdata_o <= bus_wdata_i;
         // outside bootstrap these addresses read the user sector mapped there
         test_sel_o <= bus_req_i & ~bus_wr_i & is_test_zone & bootstrap_i & ~busy_ff;
         op_start_o <= nxt_start;
         op_kind_o <= nxt_kind;
         op_phase_o <= nxt_phase;
         op_suspend_o <= nxt_suspend;
         op_resume_o <= nxt_resume;
         seq_err_o <= nxt_seq_err;
         err_update_o <= nxt_err_update;
         cell_wdata_o <= merged;
         bank_busy_o <= nxt_busy;
         reg_lock_o <= nxt_lock;
      end
   end

endmodule
`default_nettype wire

// [flash_write_control_sva.sv]
// port-level assertions of the flash write control block
`default_nettype none
module flash_write_control_sva (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic bus_req_i,
   input wire logic bus_wr_i,
   input wire logic [23:0] bus_addr_i,
   input wire logic op_done_i,
   input wire logic bus_ack_o,
   input wire logic [15:0] bus_rdata_o,
   input wire logic ext_wr_o,
   input wire logic op_start_o,
   input wire logic [1:0] op_kind_o,
   input wire logic op_phase_o,
   input wire logic op_suspend_o,
   input wire logic seq_err_o,
   input wire logic err_update_o,
   input wire logic bank_busy_o,
   input wire logic reg_lock_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   wire rd = bus_req_i && !bus_wr_i;
   wire wr = bus_req_i && bus_wr_i;
   wire bank = bus_addr_i <= 24'h04ffff;
   wire regs = bus_addr_i >= 24'h080004 && bus_addr_i <= 24'h080015;
   wire last = op_kind_o != 2'h2 || op_phase_o;
   a_ack_next:
   assert property (bus_req_i |=> bus_ack_o) else $error("no ack after request");
   a_busy_rd_trap:
   assert property (rd && bank && bank_busy_o |=> bus_rdata_o == 16'h009b) else $error("bank read not trapped");
   a_busy_wr_drop:
   assert property (wr && bank && bank_busy_o |=> !ext_wr_o) else $error("bank write passed while busy");
   a_lock_rd_trap:
   assert property (rd && regs && reg_lock_o |=> bus_rdata_o == 16'h009b) else $error("register read not trapped");
   a_lock_wr_drop:
   assert property (wr && regs && reg_lock_o |=> !ext_wr_o) else $error("register write passed while locked");
   a_test_wr_drop:
   assert property (wr && bus_addr_i <= 24'h001fff |=> !ext_wr_o) else $error("test sector write passed");
   a_low_read:
   assert property (rd && bus_addr_i == 24'h080000 |=>
      bus_rdata_o == {11'h0, $past(reg_lock_o), 2'h0, $past(bank_busy_o), 1'h0}) else $error("low register wrong");
   a_start_flags:
   assert property (op_start_o |-> bank_busy_o && reg_lock_o) else $error("start without busy and lock");
   a_busy_lock:
   assert property ($rose(bank_busy_o) |-> $rose(reg_lock_o)) else $error("busy rose without lock");
   a_done_clears:
   assert property (op_done_i && bank_busy_o && last |=>
      bank_busy_o ##1 !bank_busy_o && reg_lock_o && err_update_o ##1 !reg_lock_o)
      else $error("completion sequence wrong");
   a_err_after_busy:
   assert property (err_update_o |-> !bank_busy_o && $past(bank_busy_o)) else $error("error update while busy");
   a_suspend_free:
   assert property (op_suspend_o |-> !bank_busy_o && !reg_lock_o) else $error("suspend left flags high");
   c_erase_pre: cover property (op_start_o && op_kind_o == 2'h2 && !op_phase_o);
   c_suspend: cover property (op_suspend_o);
   c_seq_err: cover property (seq_err_o);
endmodule
`default_nettype wire

// [flash_core_model.sv]
// behavioural model of the flash array and program/erase controller
`default_nettype none
module flash_core_model (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic [23:0] bus_addr_i,
   input wire logic op_start_i,
   input wire logic op_suspend_i,
   input wire logic op_resume_i,
   input wire logic [7:0] lat_i,
   output logic [15:0] ext_rdata_o,
   output logic op_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_ff;
   // data follows the address so a stale value cannot pass for fresh
   assign ext_rdata_o = bus_addr_i[15:0] ^ 16'h5a5a;
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_ff <= 8'h00;
         op_done_o <= 1'b0;
      end else begin
         op_done_o <= cnt_ff == 8'h01;
         // each phase, pre-program included, runs its own count
         if (op_start_i || op_resume_i) begin
            cnt_ff <= lat_i;
         end else if (op_suspend_i) begin
            cnt_ff <= 8'h00;
         end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench of the flash write control block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic bus_req_i = 1'b0;
   logic bus_wr_i = 1'b0;
   logic bootstrap_i = 1'b0;
   logic error_flag_i = 1'b0;
   logic [23:0] bus_addr_i = 24'h000000;
   logic [23:0] target_addr_i = 24'h010004;
   logic [1:0] bus_be_i = 2'h3;
   logic [15:0] bus_wdata_i = 16'h0000;
   logic [5:0] sector_sel_i = 6'h01;
   logic [31:0] cell_old_i = 32'hf0f0ffff;
   logic [31:0] cell_data_i = 32'h0f00ff0f;
   logic [7:0] lat = 8'h14;
   logic [15:0] ext_rdata_i, bus_rdata_o, ext_wdata_o, q;
   logic [23:0] ext_addr_o;
   logic [1:0] ext_be_o, op_kind_o;
   logic [31:0] cell_wdata_o;
   logic op_done_i, bus_ack_o, ext_wr_o, test_sel_o, op_start_o, op_suspend_o, op_resume_o, op_phase_o;
   logic seq_err_o, err_update_o, bank_busy_o, reg_lock_o, xw, ts;
   int miscompares = 0;
   int n_compared = 0;
   int n_seq = 0;
   int n_st = 0;
   int cyc = 0;
   always #2 sys_clk_i = ~sys_clk_i;
   flash_write_control uut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus_req_i(bus_req_i), .bus_wr_i(bus_wr_i),
      .bus_addr_i(bus_addr_i), .bus_be_i(bus_be_i), .bus_wdata_i(bus_wdata_i), .bootstrap_i(bootstrap_i),
      .ext_rdata_i(ext_rdata_i), .error_flag_i(error_flag_i), .target_addr_i(target_addr_i),
      .sector_sel_i(sector_sel_i), .op_done_i(op_done_i), .cell_old_i(cell_old_i), .cell_data_i(cell_data_i),
      .bus_ack_o(bus_ack_o), .bus_rdata_o(bus_rdata_o), .ext_wr_o(ext_wr_o), .ext_addr_o(ext_addr_o),
      .ext_be_o(ext_be_o), .ext_wdata_o(ext_wdata_o), .test_sel_o(test_sel_o), .op_start_o(op_start_o),
      .op_kind_o(op_kind_o), .op_phase_o(op_phase_o), .op_suspend_o(op_suspend_o), .op_resume_o(op_resume_o),
      .seq_err_o(seq_err_o), .err_update_o(err_update_o), .cell_wdata_o(cell_wdata_o),
      .bank_busy_o(bank_busy_o), .reg_lock_o(reg_lock_o));
   flash_core_model core (.sys_clk_i, .rst_b_i, .bus_addr_i, .op_start_i(op_start_o), .op_suspend_i(op_suspend_o),
      .op_resume_i(op_resume_o), .lat_i(lat), .ext_rdata_o(ext_rdata_i), .op_done_o(op_done_i));
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cyc++;
      if (seq_err_o === 1'b1) n_seq++;
      if (op_start_o === 1'b1) n_st++;
      if (cyc == 6000) begin
         miscompares++;
         final_report;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one access; ack and read data are taken at the cycle after the request
   task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d);
      @(negedge sys_clk_i);
      bus_req_i = 1'b1;
      bus_wr_i = w;
      bus_addr_i = a;
      bus_wdata_i = d;
      @(negedge sys_clk_i);
      bus_req_i = 1'b0;
      q = bus_rdata_o;
      xw = ext_wr_o;
      ts = test_sel_o;
      chk(bus_ack_o, 1'b1);
   endtask
   task automatic rd(input logic [23:0] a, input logic [15:0] e);
      acc(1'b0, a, 16'h0000);
      chk(q, e);
   endtask
   // software polls the lock flag until it reads low
   task automatic wait_free;
      int i;
      i = 0;
      do begin
         acc(1'b0, 24'h080000, 16'h0000);
         i++;
      end while (q !== 16'h0000 && i < 200);
      chk(q, 16'h0000);
      rd(24'h080002, 16'h0000);
   endtask
   task automatic t_idle;
      rd(24'h080000, 16'h0000);
      rd(24'h080002, 16'h0000);
      rd(24'h090000, 16'h0000);
      rd(24'h012000, 16'h7a5a);
      chk(cell_wdata_o, 32'h0000ff0f);
      acc(1'b1, 24'h012000, 16'h1234);
      chk(xw, 1'b1);
      chk(ext_addr_o, 24'h012000);
      chk(ext_wdata_o, 16'h1234);
      chk(ext_be_o, 2'h3);
      acc(1'b1, 24'h000100, 16'h1234);
      chk(xw, 1'b0);
      bootstrap_i = 1'b1;
      rd(24'h000100, 16'h5b5a);
      chk(ts, 1'b1);
      bootstrap_i = 1'b0;
      rd(24'h000100, 16'h5b5a);
      chk(ts, 1'b0);
   endtask
   task automatic t_word;
      acc(1'b1, 24'h080002, 16'ha000);
      chk(op_kind_o, 2'h0);
      chk(op_phase_o, 1'b1);
      rd(24'h080000, 16'h0012);
      rd(24'h012000, 16'h009b);
      rd(24'h080008, 16'h009b);
      rd(24'h080002, 16'h009b);
      acc(1'b1, 24'h012000, 16'h1234);
      chk(xw, 1'b0);
      acc(1'b1, 24'h080010, 16'h1234);
      chk(xw, 1'b0);
      wait_free;
      rd(24'h012000, 16'h7a5a);
   endtask
   task automatic t_erase;
      int s;
      s = n_st;
      lat = 8'h05;
      acc(1'b1, 24'h080002, 16'h8800);
      chk(op_kind_o, 2'h2);
      chk(op_phase_o, 1'b0);
      wait_free;
      chk(n_st, s + 2);
      // an empty sector set is a sequence error and never starts the array
      sector_sel_i = 6'h00;
      s = n_seq;
      acc(1'b1, 24'h080002, 16'h8800);
      wait_free;
      chk(n_seq, s + 1);
      sector_sel_i = 6'h01;
   endtask
   task automatic t_protect;
      int s;
      s = n_seq;
      target_addr_i = 24'h08dfc0;
      acc(1'b1, 24'h080002, 16'h8100);
      // a refused start holds busy for one cycle only; the lock trails it by one more
      rd(24'h080000, 16'h0010);
      wait_free;
      chk(n_seq, s + 1);
      target_addr_i = 24'h08dfb8;
      acc(1'b1, 24'h080002, 16'h8100);
      rd(24'h080000, 16'h0012);
      wait_free;
      chk(n_seq, s + 1);
   endtask
   task automatic t_suspend;
      lat = 8'h28;
      target_addr_i = 24'h010008;
      acc(1'b1, 24'h080002, 16'h9000);
      acc(1'b1, 24'h080002, 16'h4000);
      rd(24'h080000, 16'h0000);
      rd(24'h012000, 16'h7a5a);
      rd(24'h080002, 16'h5000);
      acc(1'b1, 24'h080002, 16'h9000);
      rd(24'h080000, 16'h0012);
      wait_free;
   endtask
   task automatic t_refused;
      error_flag_i = 1'b1;
      acc(1'b1, 24'h080002, 16'ha000);
      rd(24'h080000, 16'h0000);
      error_flag_i = 1'b0;
      // a stored suspend bit refuses the next start; that write clears it again
      acc(1'b1, 24'h080002, 16'h4000);
      acc(1'b1, 24'h080002, 16'ha000);
      rd(24'h080000, 16'h0000);
      rd(24'h080002, 16'h2000);
      acc(1'b1, 24'h080002, 16'h0000);
   endtask
   // reset dropped in the middle of a word program must leave every flag low
   task automatic t_reset;
      acc(1'b1, 24'h080002, 16'ha000);
      rst_b_i = 1'b0;
      @(negedge sys_clk_i);
      chk(bank_busy_o, 1'b0);
      chk(reg_lock_o, 1'b0);
      rst_b_i = 1'b1;
      rd(24'h080000, 16'h0000);
      rd(24'h080002, 16'h0000);
   endtask
   initial begin
      repeat (20) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      t_idle;
      t_word;
      t_erase;
      t_protect;
      t_suspend;
      t_refused;
      t_reset;
      final_report;
   end
endmodule
bind flash_write_control flash_write_control_sva chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
   .bus_req_i(bus_req_i), .bus_wr_i(bus_wr_i), .bus_addr_i(bus_addr_i), .op_done_i(op_done_i),
   .bus_ack_o(bus_ack_o), .bus_rdata_o(bus_rdata_o), .ext_wr_o(ext_wr_o), .op_start_o(op_start_o),
   .op_kind_o(op_kind_o), .op_phase_o(op_phase_o), .op_suspend_o(op_suspend_o), .seq_err_o(seq_err_o),
   .err_update_o(err_update_o), .bank_busy_o(bank_busy_o), .reg_lock_o(reg_lock_o));
`default_nettype wire
